// ===== rtc_subsecond_offset_leap_ctrl.sv
// Sub-second offset, counter halt, leap year and leap second logic
`default_nettype none

module rtc_subsecond_offset_leap_ctrl #(
    parameter int unsigned TICK_DIV = rtc_adj_pkg::TICK_DIV
) (
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    input  wire rtc_adj_pkg::reg_req_t reg_req,
    output logic [7:0]                 reg_rdata,
    output logic [32:0]                bin_seconds
);
    import rtc_adj_pkg::*;

    // ************************************************************
    // Helper functions
    // ************************************************************
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    // BCD year divisible by four: even tens with 0/4/8, odd tens with 2/6
    function automatic logic leap_year(input logic [7:0] y);
        if (y[4] == 1'b0) begin
            leap_year = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) ||
                        (y[3:0] == 4'h8);
        end else begin
            leap_year = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end
    endfunction

    function automatic logic [7:0] days_max(input logic [7:0] m,
                                            input logic [7:0] y);
        unique case (m)
            MON_FEB:                    days_max = leap_year(y) ?
                                                   DAYS_29 : DAYS_28;
            8'h04, 8'h06, 8'h09, 8'h11: days_max = DAYS_30;
            default:                    days_max = DAYS_31;
        endcase
    endfunction

    // Primary and mirror addresses reach the same calendar slot
    function automatic logic [2:0] cal_index(input logic [7:0] a);
        if (a <= ADDR_YEAR) begin
            cal_index = a[2:0];
        end else if (a >= ADDR_SECOND_COUNT_MIRROR && a <= ADDR_YEAR_MIR) begin
            cal_index = 3'(a - ADDR_SECOND_COUNT_MIRROR);
        end else begin
            cal_index = CAL_NONE;
        end
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    logic [7:0]        sec_ff, min_ff, hour_ff, day_ff, mon_ff, year_ff;
    logic [7:0]        nxt_sec, nxt_min, nxt_hour, nxt_day, nxt_mon;
    logic [7:0]        nxt_year;
    logic [2:0]        wday_ff, nxt_wday;
    logic [FRAC_W-1:0] frac_ff, nxt_frac;
    logic [BIN_W-1:0]  bin_ff, nxt_bin;
    logic [ADJ_W-1:0]  adj_val_ff, nxt_adj_val;
    adj_state_t        adj_state_ff, nxt_adj_state;
    logic              stop_ff, nxt_stop;
    logic [7:0]        rdata_ff, nxt_rdata;

    logic       tick;
    logic       sec_upd;
    logic       sec_inc;
    logic       adj_apply;
    logic       wr_en;
    logic [2:0] wr_idx;
    logic [2:0] rd_idx;

    timebase_1024 #(
        .DIV (TICK_DIV)
    ) u_timebase (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .run     (!stop_ff),
        .tick    (tick)
    );

    assign wr_en     = reg_req.wr;
    assign wr_idx    = cal_index(reg_req.addr);
    assign rd_idx    = cal_index(reg_req.addr);
    assign sec_upd   = tick && !stop_ff && (frac_ff == FRAC_MAX);
    assign adj_apply = sec_upd && (adj_state_ff == ADJ_ARMED);
    // A negative offset swallows this second, so the count loses time
    assign sec_inc   = sec_upd && !(adj_apply && adj_val_ff[ADJ_SIGN]);

    // ************************************************************
    // Counting chain and register writes
    // ************************************************************
    always_comb begin
        logic c_min;
        logic c_hour;
        logic c_day;
        logic c_mon;
        c_min     = 1'b0;
        c_hour    = 1'b0;
        c_day     = 1'b0;
        c_mon     = 1'b0;
        nxt_sec   = sec_ff;
        nxt_min   = min_ff;
        nxt_hour  = hour_ff;
        nxt_wday  = wday_ff;
        nxt_day   = day_ff;
        nxt_mon   = mon_ff;
        nxt_year  = year_ff;
        nxt_frac  = frac_ff;
        nxt_bin   = bin_ff;
        nxt_stop  = stop_ff;
        nxt_adj_val   = adj_val_ff;
        nxt_adj_state = adj_state_ff;
        // Fraction counts only while running; halted tick never fires
        if (tick && !stop_ff) begin
            nxt_frac = frac_ff + 1'b1;
        end
        if (adj_apply) begin
            // Low ten bits equal count+offset modulo 1024 for both signs
            nxt_frac      = adj_val_ff[FRAC_W-1:0];
            nxt_adj_state = ADJ_READY;
        end
        if (sec_inc) begin
            nxt_bin = bin_ff + 1'b1;
            if (sec_ff == SEC_LEAP) begin
                nxt_sec = BCD_ZERO;
            end else if (sec_ff == SEC_LAST) begin
                nxt_sec = BCD_ZERO;
                c_min   = 1'b1;
            end else begin
                nxt_sec = bcd_inc(sec_ff);
            end
        end
        if (c_min) begin
            nxt_min = (min_ff == MIN_LAST) ? BCD_ZERO : bcd_inc(min_ff);
            c_hour  = (min_ff == MIN_LAST);
        end
        if (c_hour) begin
            nxt_hour = (hour_ff == HOUR_LAST) ? BCD_ZERO : bcd_inc(hour_ff);
            c_day    = (hour_ff == HOUR_LAST);
        end
        if (c_day) begin
            nxt_wday = (wday_ff == WDAY_LAST) ? 3'h0 : wday_ff + 3'h1;
            // February limit follows the leap test
            c_mon    = (day_ff == days_max(mon_ff, year_ff));
            nxt_day  = c_mon ? BCD_ONE : bcd_inc(day_ff);
        end
        if (c_mon) begin
            nxt_mon = (mon_ff == MON_LAST) ? BCD_ONE : bcd_inc(mon_ff);
            if (mon_ff == MON_LAST) begin
                nxt_year = (year_ff == YEAR_LAST) ? BCD_ZERO
                                                  : bcd_inc(year_ff);
            end
        end
        // Host writes win over counting in the same cycle
        if (wr_en) begin
            unique case (wr_idx)
                CAL_SEC:  nxt_sec  = reg_req.wdata;
                CAL_MIN:  nxt_min  = reg_req.wdata;
                CAL_HOUR: nxt_hour = reg_req.wdata;
                CAL_WDAY: nxt_wday = reg_req.wdata[2:0];
                CAL_DAY:  nxt_day  = reg_req.wdata;
                CAL_MON:  nxt_mon  = reg_req.wdata;
                CAL_YEAR: nxt_year = reg_req.wdata;
                CAL_NONE: ;
            endcase
            unique case (reg_req.addr)
                ADDR_SEC:       nxt_frac = '0;
                ADDR_FRAC_LOW:  nxt_frac[1:0] = reg_req.wdata[1:0];
                ADDR_FRAC_HIGH: nxt_frac[9:2] = reg_req.wdata;
                ADDR_ADJ_LOW: begin
                    nxt_adj_val[4:0] = reg_req.wdata[4:0];
                    // A new start beats a completion in the same cycle
                    if (reg_req.wdata[ADJ_START]) begin
                        nxt_adj_state = ADJ_ARMED;
                    end
                end
                ADDR_ADJ_HIGH:  nxt_adj_val[10:5] = reg_req.wdata[5:0];
                ADDR_HALT:      nxt_stop = reg_req.wdata[HALT_STOP];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sec_ff       <= BCD_ZERO;
            min_ff       <= BCD_ZERO;
            hour_ff      <= BCD_ZERO;
            wday_ff      <= 3'h0;
            day_ff       <= BCD_ONE;
            mon_ff       <= BCD_ONE;
            year_ff      <= BCD_ZERO;
            frac_ff      <= '0;
            bin_ff       <= '0;
            adj_val_ff   <= '0;
            adj_state_ff <= ADJ_READY;
            stop_ff      <= 1'b0;
        end else begin
            sec_ff       <= nxt_sec;
            min_ff       <= nxt_min;
            hour_ff      <= nxt_hour;
            wday_ff      <= nxt_wday;
            day_ff       <= nxt_day;
            mon_ff       <= nxt_mon;
            year_ff      <= nxt_year;
            frac_ff      <= nxt_frac;
            bin_ff       <= nxt_bin;
            adj_val_ff   <= nxt_adj_val;
            adj_state_ff <= nxt_adj_state;
            stop_ff      <= nxt_stop;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    // Registered so the answer stays stable until the next read strobe
    always_comb begin
        nxt_rdata = rdata_ff;
        if (reg_req.rd) begin
            unique case (rd_idx)
                CAL_SEC:  nxt_rdata = sec_ff;
                CAL_MIN:  nxt_rdata = min_ff;
                CAL_HOUR: nxt_rdata = hour_ff;
                CAL_WDAY: nxt_rdata = {5'h00, wday_ff};
                CAL_DAY:  nxt_rdata = day_ff;
                CAL_MON:  nxt_rdata = mon_ff;
                CAL_YEAR: nxt_rdata = year_ff;
                CAL_NONE: begin
                    unique case (reg_req.addr)
                        ADDR_FRAC_LOW:  nxt_rdata = {6'h00, frac_ff[1:0]};
                        ADDR_FRAC_HIGH: nxt_rdata = frac_ff[9:2];
                        ADDR_ADJ_LOW:   nxt_rdata =
                            {1'b0, adj_state_ff == ADJ_READY, 1'b0,
                             adj_val_ff[4:0]};
                        ADDR_ADJ_HIGH:  nxt_rdata =
                            {2'b00, adj_val_ff[10:5]};
                        ADDR_HALT:      nxt_rdata = {7'h00, stop_ff};
                        default:        nxt_rdata = 8'h00;
                    endcase
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata   = rdata_ff;
    assign bin_seconds = bin_ff;

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_start_write;
        reg_req.wr && reg_req.addr == ADDR_ADJ_LOW &&
        reg_req.wdata[ADJ_START];
    endsequence

    sequence s_quiet_apply;
        adj_apply && !reg_req.wr;
    endsequence

    property p_start_clears_done;
        @(posedge clk_sys) disable iff (!resetn)
        s_start_write |=> adj_state_ff == ADJ_ARMED;
    endproperty
    a_start_clears_done: assert property (p_start_clears_done)
        else $error("start write did not clear done flag");

    property p_apply_once;
        @(posedge clk_sys) disable iff (!resetn)
        s_quiet_apply |=> adj_state_ff == ADJ_READY && !adj_apply;
    endproperty
    a_apply_once: assert property (p_apply_once)
        else $error("offset not completed once after applying");

    property p_apply_value;
        @(posedge clk_sys) disable iff (!resetn)
        s_quiet_apply |=> frac_ff == $past(adj_val_ff[9:0]);
    endproperty
    a_apply_value: assert property (p_apply_value)
        else $error("fraction count not loaded with offset");

    property p_negative_holds_second;
        @(posedge clk_sys) disable iff (!resetn)
        s_quiet_apply ##0 adj_val_ff[ADJ_SIGN] |=> $stable(sec_ff) &&
                                                   $stable(bin_ff);
    endproperty
    a_negative_holds_second: assert property (p_negative_holds_second)
        else $error("negative offset let the second advance");

    property p_stop_freezes;
        @(posedge clk_sys) disable iff (!resetn)
        (stop_ff && !reg_req.wr) [*2] |-> $stable(frac_ff) &&
                                          $stable(sec_ff) && $stable(bin_ff);
    endproperty
    a_stop_freezes: assert property (p_stop_freezes)
        else $error("counter moved while halted");

    property p_leap_rollover;
        @(posedge clk_sys) disable iff (!resetn)
        sec_ff == SEC_LEAP && sec_inc && !reg_req.wr
            |=> sec_ff == BCD_ZERO && $stable(min_ff);
    endproperty
    a_leap_rollover: assert property (p_leap_rollover)
        else $error("leap second did not roll to zero");

    property p_leap_readback;
        @(posedge clk_sys) disable iff (!resetn)
        reg_req.rd && rd_idx == CAL_SEC && sec_ff == SEC_LEAP
            |=> reg_rdata == SEC_LEAP;
    endproperty
    a_leap_readback: assert property (p_leap_readback)
        else $error("seconds did not read back as sixty");

    property p_sec_write_clears_frac;
        @(posedge clk_sys) disable iff (!resetn)
        reg_req.wr && reg_req.addr == ADDR_SEC |=> frac_ff == '0;
    endproperty
    a_sec_write_clears_frac: assert property (p_sec_write_clears_frac)
        else $error("primary seconds write kept fraction");

    property p_feb_limit;
        @(posedge clk_sys) disable iff (!resetn)
        sec_inc && !reg_req.wr && mon_ff == MON_FEB && day_ff == DAYS_28 &&
        hour_ff == HOUR_LAST && min_ff == MIN_LAST && sec_ff == SEC_LAST
            |=> day_ff == (leap_year(year_ff) ? DAYS_29 : BCD_ONE);
    endproperty
    a_feb_limit: assert property (p_feb_limit)
        else $error("February day limit wrong for year");

endmodule // rtc_subsecond_offset_leap_ctrl

`default_nettype wire

// ===== rtc_adj_pkg.sv
// Package with register map, field layout and timing for the RTC adjust block
`default_nettype none

package rtc_adj_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_HZ     = 100_000_000;
    localparam int unsigned TICK_HZ    = 1024;
    // Longest whole period of the timebase, rounded down
    localparam int unsigned TICK_DIV   = CLK_HZ / TICK_HZ;
    localparam int unsigned TICK_CNT_W = 17;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] ADDR_SEC        = 8'h00;
    localparam logic [7:0] ADDR_YEAR       = 8'h06;
    localparam logic [7:0] ADDR_FRAC_LOW   = 8'h10;
    localparam logic [7:0] ADDR_FRAC_HIGH  = 8'h11;
    localparam logic [7:0] ADDR_SECOND_COUNT_MIRROR    = 8'h12;
    localparam logic [7:0] ADDR_YEAR_MIR   = 8'h18;
    localparam logic [7:0] ADDR_ADJ_LOW    = 8'h1c;
    localparam logic [7:0] ADDR_ADJ_HIGH   = 8'h1d;
    localparam logic [7:0] ADDR_HALT       = 8'h1e;

    // Calendar slot index, shared by primary and mirror addresses
    localparam logic [2:0] CAL_SEC   = 3'h0;
    localparam logic [2:0] CAL_MIN   = 3'h1;
    localparam logic [2:0] CAL_HOUR  = 3'h2;
    localparam logic [2:0] CAL_WDAY  = 3'h3;
    localparam logic [2:0] CAL_DAY   = 3'h4;
    localparam logic [2:0] CAL_MON   = 3'h5;
    localparam logic [2:0] CAL_YEAR  = 3'h6;
    localparam logic [2:0] CAL_NONE  = 3'h7;

    // ************************************************************
    // Field layout
    // ************************************************************
    localparam int unsigned ADJ_W        = 11;
    localparam int unsigned FRAC_W       = 10;
    localparam int unsigned ADJ_SIGN     = 10;
    localparam int unsigned ADJ_START    = 7;   // adjust_start_bit
    localparam int unsigned ADJ_DONE     = 6;   // adjust_done_flag
    localparam int unsigned HALT_STOP    = 0;
    localparam int unsigned BIN_W        = 33;
    localparam logic [9:0]  FRAC_MAX     = 10'h3ff;

    // ************************************************************
    // Counter limits and reset values (BCD)
    // ************************************************************
    localparam logic [7:0] SEC_LAST   = 8'h59;
    localparam logic [7:0] SEC_LEAP   = 8'h60;
    localparam logic [7:0] MIN_LAST   = 8'h59;
    localparam logic [7:0] HOUR_LAST  = 8'h23;
    localparam logic [2:0] WDAY_LAST  = 3'h6;
    localparam logic [7:0] MON_LAST   = 8'h12;
    localparam logic [7:0] MON_FEB    = 8'h02;
    localparam logic [7:0] YEAR_LAST  = 8'h99;
    localparam logic [7:0] BCD_ZERO   = 8'h00;
    localparam logic [7:0] BCD_ONE    = 8'h01;
    localparam logic [7:0] DAYS_31    = 8'h31;
    localparam logic [7:0] DAYS_30    = 8'h30;
    localparam logic [7:0] DAYS_29    = 8'h29;
    localparam logic [7:0] DAYS_28    = 8'h28;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef enum logic {
        ADJ_READY = 1'b0,
        ADJ_ARMED = 1'b1
    } adj_state_t;

endpackage

`default_nettype wire

// ===== timebase_1024.sv
// Divider that makes the 1024 Hz counting tick from the system clock
`default_nettype none

module timebase_1024 #(
    parameter int unsigned DIV = rtc_adj_pkg::TICK_DIV
) (
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic run,
    output logic      tick
);
    import rtc_adj_pkg::*;

    localparam logic [TICK_CNT_W-1:0] LAST = TICK_CNT_W'(DIV - 1);

    logic [TICK_CNT_W-1:0] cnt_ff;
    logic [TICK_CNT_W-1:0] nxt_cnt;

    // Held at zero while halted, so a restart begins a full period
    always_comb begin
        if (!run || cnt_ff == LAST) begin
            nxt_cnt = '0;
        end else begin
            nxt_cnt = cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign tick = run && (cnt_ff == LAST);

endmodule // timebase_1024

`default_nettype wire

// ===== rtc_host_model.sv
// Host model that issues register strobes towards the adjust block
`default_nettype none

module rtc_host_model (
    input  wire logic                 clk_sys,
    input  wire logic [7:0]           reg_rdata,
    output var  rtc_adj_pkg::reg_req_t reg_req
);
    timeunit 1ns;
    timeprecision 1ps;
    import rtc_adj_pkg::*;

    // Bus idle at time zero
    initial begin
        reg_req = '0;
    end

    // ************************************************************
    // Access tasks
    // ************************************************************
    // Strobe set on a falling edge and held over exactly one rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_req.wr    = 1'b1;
        reg_req.addr  = a;
        reg_req.wdata = d;
        @(negedge clk_sys);
        // Released lines flip so stale values can never be mistaken
        reg_req.wr    = 1'b0;
        reg_req.addr  = ~a;
        reg_req.wdata = ~d;
    endtask

    // Data is taken one cycle late; it holds until the next read
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        reg_req.rd   = 1'b1;
        reg_req.addr = a;
        @(negedge clk_sys);
        reg_req.rd   = 1'b0;
        reg_req.addr = ~a;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
endmodule // rtc_host_model

`default_nettype wire

// ===== tb_rtc_subsecond_offset_leap_ctrl.sv
// Self-checking bench for the offset, halt and leap logic
`default_nettype none

module tb_rtc_subsecond_offset_leap_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import rtc_adj_pkg::*;

    // Short tick keeps a whole second near 8192 clocks
    localparam int unsigned DIV = 8;

    rtc_adj_pkg::reg_req_t reg_req;
    logic                  clk_sys;
    logic                  resetn;
    logic [7:0]            reg_rdata;
    logic [32:0]           bin_seconds;
    logic [32:0]           bin_ref;
    logic [7:0]            rv;
    logic [9:0]            frac;
    int                    bad_count;
    int                    checked;

`define CHK(name, exp, got) \
    begin \
        checked++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("[FAIL] %s expected %h seen %h", name, exp, got); \
        end \
    end

    rtc_subsecond_offset_leap_ctrl #(.TICK_DIV(DIV))
        rtc_subsecond_offset_leap_ctrl_inst (.clk_sys(clk_sys),
        .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .bin_seconds(bin_seconds));

    rtc_host_model rtc_host_model_inst (.clk_sys(clk_sys),
        .reg_rdata(reg_rdata), .reg_req(reg_req));

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        rtc_host_model_inst.wr(a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        rtc_host_model_inst.rd(a, rv);
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        `CHK($sformatf("reg %h", a), e, rv)
    endtask

    // Low address first, as the host pairs the two halves
    task automatic rd_frac();
        rd(ADDR_FRAC_LOW);
        frac[1:0] = rv[1:0];
        rd(ADDR_FRAC_HIGH);
        frac[9:2] = rv;
    endtask

    task automatic wr_frac(input logic [9:0] f);
        wr(ADDR_FRAC_LOW, {6'h00, f[1:0]});
        wr(ADDR_FRAC_HIGH, f[9:2]);
    endtask

    // Release the halt, poll a register, then halt again
    task automatic run_until(input logic [7:0] a, input logic [7:0] v);
        wr(ADDR_HALT, 8'h00);
        for (int i = 0; i < 4000; i++) begin
            rd(a);
            if (rv === v) begin
                wr(ADDR_HALT, 8'h01);
                return;
            end
        end
        bad_count++;
        $display("[FAIL] poll %h expected %h seen %h", a, v, rv);
        report_and_stop();
    endtask

    // ************************************************************
    // Clock and sequence
    // ************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        bad_count = 0;
        checked = 0;
        resetn = 1'b0;
        repeat (10) @(negedge clk_sys);
        resetn = 1'b1;
        chk_reg(ADDR_ADJ_LOW, 8'h40);
        chk_reg(8'h0f, 8'h00);
        $display("test reset done");
        // Frozen counters keep a directly written fraction
        wr(ADDR_HALT, 8'h01);
        chk_reg(ADDR_HALT, 8'h01);
        wr_frac(10'h3fd);
        bin_ref = bin_seconds;
        repeat (200) @(negedge clk_sys);
        rd_frac();
        `CHK("frac", 10'h3fd, frac)
        `CHK("bin", bin_ref, bin_seconds)
        $display("test halt done");
        // Gain of 5 ticks; a later second must not apply it again
        wr(ADDR_ADJ_HIGH, 8'h00);
        wr(ADDR_ADJ_LOW, 8'h85);
        chk_reg(ADDR_ADJ_LOW, 8'h05);
        run_until(ADDR_ADJ_LOW, 8'h45);
        rd_frac();
        `CHK("frac gain", 1'b1, (frac inside {10'h005, 10'h006}))
        chk_reg(ADDR_SEC, 8'h01);
        `CHK("bin", bin_ref + 33'h1, bin_seconds)
        wr_frac(10'h3fd);
        run_until(ADDR_SEC, 8'h02);
        rd_frac();
        `CHK("frac once", 1'b1, (frac inside {10'h000, 10'h001}))
        chk_reg(ADDR_ADJ_LOW, 8'h45);
        $display("test gain done");
        // Loss of 2 ticks suppresses the second step
        wr(ADDR_SECOND_COUNT_MIRROR, 8'h10);
        wr_frac(10'h3fd);
        wr(ADDR_ADJ_HIGH, 8'h3f);
        wr(ADDR_ADJ_LOW, 8'h9e);
        bin_ref = bin_seconds;
        run_until(ADDR_ADJ_LOW, 8'h5e);
        rd_frac();
        `CHK("frac loss", 1'b1, (frac inside {10'h3fe, 10'h3ff}))
        chk_reg(ADDR_SEC, 8'h10);
        `CHK("bin", bin_ref, bin_seconds)
        $display("test loss done");
        // Leap second through the mirror; primary write clears fraction
        wr_frac(10'h3fe);
        wr(ADDR_SEC, 8'h00);
        rd_frac();
        `CHK("frac clear", 10'h000, frac)
        wr(ADDR_SECOND_COUNT_MIRROR, 8'h60);
        chk_reg(ADDR_SEC, 8'h60);
        chk_reg(ADDR_SECOND_COUNT_MIRROR, 8'h60);
        wr_frac(10'h3fe);
        run_until(ADDR_SEC, 8'h00);
        chk_reg(8'h01, 8'h00);
        wr_frac(10'h3fe);
        run_until(ADDR_SEC, 8'h01);
        $display("test leap second done");
        // February 28 rollover in a leap and a common year
        for (int i = 0; i < 2; i++) begin
            wr(8'h01, 8'h59);
            wr(8'h02, 8'h23);
            wr(8'h04, 8'h28);
            wr(8'h05, 8'h02);
            wr(ADDR_YEAR, (i == 0) ? 8'h04 : 8'h03);
            wr(ADDR_SEC, 8'h59);
            wr_frac(10'h3ff);
            run_until(8'h04, (i == 0) ? 8'h29 : 8'h01);
            chk_reg(8'h05, (i == 0) ? 8'h02 : 8'h03);
            // Weekday steps with every day rollover, read via its mirror
            chk_reg(8'h15, 8'(i + 1));
        end
        $display("test leap year done");
        report_and_stop();
    end
endmodule // tb_rtc_subsecond_offset_leap_ctrl

`default_nettype wire
